//--- bcs_cpl.sv
// completion merger toward the secondary side
`timescale 1ns/1ps
`default_nettype none
module bcs_cpl #(
   parameter int DW = 32,
   parameter int TW = 8
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // link to the other parts
   bcs_link_if.cpl            lnk,
   // completions from the primary side
   input  wire logic          pcpl_valid,
   output logic               pcpl_ready,
   input  wire logic [TW-1:0] pcpl_tag,
   input  wire logic [DW-1:0] pcpl_data,
   // completions to the secondary side
   output logic               scpl_valid,
   input  wire logic          scpl_ready,
   output logic [TW-1:0]      scpl_tag,
   output logic [DW-1:0]      scpl_data,
   output logic [2:0]         scpl_status
);
   import bcs_pkg::*;

   logic          ur_v;
   logic [TW-1:0] ur_t;
   logic          load;

   assign load        = ~scpl_valid | scpl_ready;
   assign pcpl_ready  = load;
   assign lnk.ur_full = ur_v;

   // one pending unsupported-request answer
   always_ff @(posedge clk) begin
      if (rst) begin
         ur_v <= 1'b0;
         ur_t <= '0;
      end else if (lnk.ur_req) begin
         ur_v <= 1'b1;
         ur_t <= lnk.ur_tag;
      end else if (load & ~pcpl_valid) begin
         ur_v <= 1'b0;
      end
   end

   // primary completions first, local answers when idle
   always_ff @(posedge clk) begin
      if (rst) begin
         scpl_valid  <= 1'b0;
         scpl_tag    <= '0;
         scpl_data   <= '0;
         scpl_status <= CPL_SC;
      end else if (load) begin
         if (pcpl_valid) begin
            scpl_valid  <= 1'b1;
            scpl_tag    <= pcpl_tag;
            scpl_data   <= pcpl_data;
            scpl_status <= CPL_SC;
         end else if (ur_v) begin
            scpl_valid  <= 1'b1;
            scpl_tag    <= ur_t;
            scpl_data   <= '0;
            scpl_status <= CPL_UR;
         end else begin
            scpl_valid  <= 1'b0;
         end
      end
   end

   property p_cpl_pass;
      @(posedge clk) disable iff (rst)
         pcpl_valid && pcpl_ready |=> scpl_valid && scpl_tag == $past(pcpl_tag)
            && scpl_status == CPL_SC;
   endproperty
   a_cpl_pass: assert property (p_cpl_pass)
      else $error("primary completion not passed on next cycle");

   property p_ur_held;
      @(posedge clk) disable iff (rst) lnk.ur_req |=> ur_v && ur_t == $past(lnk.ur_tag);
   endproperty
   a_ur_held: assert property (p_ur_held)
      else $error("illegal read left without a pending answer");
endmodule
`default_nettype wire

//--- bcs_fwd.sv
// upstream request forwarder with master-enable gating
`timescale 1ns/1ps
`default_nettype none
module bcs_fwd #(
   parameter int AW = 32,
   parameter int DW = 32,
   parameter int TW = 8
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // link to the other parts
   bcs_link_if.fwd            lnk,
   // upstream requests from the secondary side
   input  wire logic          up_valid,
   output logic               up_ready,
   input  wire logic          up_write,
   input  wire logic          up_io,
   input  wire logic [AW-1:0] up_addr,
   input  wire logic [3:0]    up_be,
   input  wire logic [DW-1:0] up_data,
   input  wire logic [TW-1:0] up_tag,
   // requests toward the primary side
   output logic               pri_valid,
   input  wire logic          pri_ready,
   output logic               pri_write,
   output logic               pri_io,
   output logic [AW-1:0]      pri_addr,
   output logic [3:0]         pri_be,
   output logic [DW-1:0]      pri_data,
   output logic [TW-1:0]      pri_tag,
   // illegal cycle sink
   output logic               ill_valid,
   input  wire logic          ill_ready
);
   import bcs_pkg::*;

   logic st_v;
   logic st_ill;
   logic pri_go;
   logic ill_go;
   logic take;

   function automatic logic [3:0] ill_be_f(input logic wr, input logic [3:0] be);
      return wr ? 4'h0 : be;
   endfunction

   assign pri_valid = st_v & ~st_ill & lnk.master_en;
   assign ill_valid = st_v & st_ill & (pri_write | ~lnk.ur_full);
   assign pri_go    = pri_valid & pri_ready;
   assign ill_go    = ill_valid & ill_ready;
   assign up_ready  = ~st_v | pri_go | ill_go;
   assign take      = up_valid & up_ready;
   assign lnk.ur_req = ill_go & ~pri_write;
   assign lnk.ur_tag = pri_tag;

   always_ff @(posedge clk) begin
      if (rst) begin
         st_v <= 1'b0;
      end else if (take) begin
         st_v <= 1'b1;
      end else if (pri_go | ill_go) begin
         st_v <= 1'b0;
      end
   end

   // payload; a held request turns illegal if the enable drops
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ill    <= 1'b0;
         pri_write <= 1'b0;
         pri_io    <= 1'b0;
         pri_addr  <= '0;
         pri_be    <= 4'h0;
         pri_data  <= '0;
         pri_tag   <= '0;
      end else if (take) begin
         st_ill    <= ~lnk.master_en;
         pri_write <= up_write;
         pri_io    <= up_io & lnk.master_en;
         pri_addr  <= lnk.master_en ? up_addr : AW'(ILL_ADDR);
         pri_be    <= lnk.master_en ? up_be : ill_be_f(up_write, up_be);
         pri_data  <= up_data;
         pri_tag   <= up_tag;
      end else if (st_v & ~st_ill & ~lnk.master_en) begin
         st_ill    <= 1'b1;
         pri_io    <= 1'b0;
         pri_addr  <= AW'(ILL_ADDR);
         pri_be    <= ill_be_f(pri_write, pri_be);
      end
   end

   property p_no_pri_wo_master;
      @(posedge clk) disable iff (rst) !lnk.master_en |-> !pri_valid;
   endproperty
   a_no_pri_wo_master: assert property (p_no_pri_wo_master)
      else $error("primary request while master enable is off");

   property p_ill_write;
      @(posedge clk) disable iff (rst)
         ill_valid && pri_write |-> pri_addr == AW'(ILL_ADDR) && pri_be == 4'h0;
   endproperty
   a_ill_write: assert property (p_ill_write)
      else $error("illegal write not aimed at sink with zero enables");
endmodule
`default_nettype wire

//--- bcs_link_if.sv
// link between the register core, request forwarder and completion merger
`timescale 1ns/1ps
`default_nettype none
interface bcs_link_if #(
   parameter int TW = 8
);
   logic          master_en;
   logic          ur_req;
   logic [TW-1:0] ur_tag;
   logic          ur_full;
   modport ctl (output master_en);
   modport fwd (input master_en, input ur_full, output ur_req, output ur_tag);
   modport cpl (input ur_req, input ur_tag, output ur_full);
endinterface
`default_nettype wire

//--- bcs_pkg.sv
// constants for the bridge command and status bits block
package bcs_pkg;
   // register byte offsets
   localparam logic [7:0]  CMD_OFF         = 8'h04;
   localparam logic [7:0]  STS_OFF         = 8'h06;
   // command field positions
   localparam int          CMD_IOWIN_BIT   = 0;
   localparam int          CMD_MEMWIN_BIT  = 1;
   localparam int          CMD_MASTER_BIT  = 2;
   localparam int          CMD_PARITY_BIT  = 6;
   localparam int          CMD_SERRMSG_BIT = 8;
   // status field positions
   localparam int          STS_CAPL_BIT    = 4;
   localparam int          STS_MPE_BIT     = 8;
   localparam int          STS_MABORT_BIT  = 13;
   localparam int          STS_SYSERR_BIT  = 14;
   localparam int          STS_PARDET_BIT  = 15;
   // reset values and write masks
   localparam logic [15:0] CMD_RESET       = 16'h0000;
   localparam logic [15:0] CMD_WMASK       = 16'h0147;
   localparam logic [15:0] STS_RESET       = 16'h0010;
   // illegal cycle target and completion status codes
   localparam logic [31:0] ILL_ADDR        = 32'h000C0000;
   localparam logic [2:0]  CPL_SC          = 3'h0;
   localparam logic [2:0]  CPL_UR          = 3'h1;
endpackage

//--- bcs_pri_model.sv
// primary-side model: request sink with optional stall and completion source
`timescale 1ns/1ps
`default_nettype none
module bcs_pri_model (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst,
   // request sinks
   input  wire logic   pri_valid,
   input  wire logic   ill_valid,
   output logic        pri_ready,
   output logic        ill_ready,
   // completion source
   input  wire logic   pcpl_ready,
   output logic        pcpl_valid,
   output logic [7:0]  pcpl_tag,
   output logic [31:0] pcpl_data
);
   int stall = 0;
   int waited = 0;
   // ready only after the chosen number of stall cycles
   always @(posedge clk) begin
      if (rst || !(pri_valid || ill_valid) || pri_ready) waited <= 0;
      else waited <= waited + 1;
   end
   assign pri_ready = (waited >= stall);
   assign ill_ready = pri_ready;
   initial begin
      {pcpl_valid, pcpl_tag, pcpl_data} = '0;
   end
   // one completion, held until taken, then lines show inverted values
   task automatic send_cpl(input logic [7:0] t, input logic [31:0] d);
      int n;
      @(negedge clk);
      {pcpl_valid, pcpl_tag, pcpl_data} = {1'b1, t, d};
      n = 0;
      while (pcpl_ready !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      {pcpl_valid, pcpl_tag, pcpl_data} = {1'b0, ~t, ~d};
   endtask
endmodule
`default_nettype wire

//--- bcs_top.sv
// bridge command and status bits with upstream gating and window decode
`timescale 1ns/1ps
`default_nettype none
module bcs_top #(
   parameter int AW = 32,
   parameter int DW = 32,
   parameter int TW = 8
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // configuration access
   input  wire logic          cfg_req,
   input  wire logic          cfg_we,
   input  wire logic [7:0]    cfg_addr,
   input  wire logic [1:0]    cfg_be,
   input  wire logic [15:0]   cfg_wdata,
   output logic               cfg_ack,
   output logic [15:0]        cfg_rdata,
   // primary-side error events
   input  wire logic          err_fatal,
   input  wire logic          err_nonfatal,
   input  wire logic          mdpe_event,
   output logic               serr_msg,
   // upstream requests from the secondary side
   input  wire logic          up_valid,
   output logic               up_ready,
   input  wire logic          up_write,
   input  wire logic          up_io,
   input  wire logic [AW-1:0] up_addr,
   input  wire logic [3:0]    up_be,
   input  wire logic [DW-1:0] up_data,
   input  wire logic [TW-1:0] up_tag,
   // requests toward the primary side
   output logic               pri_valid,
   input  wire logic          pri_ready,
   output logic               pri_write,
   output logic               pri_io,
   output logic [AW-1:0]      pri_addr,
   output logic [3:0]         pri_be,
   output logic [DW-1:0]      pri_data,
   output logic [TW-1:0]      pri_tag,
   // illegal cycle sink
   output logic               ill_valid,
   input  wire logic          ill_ready,
   // completions from the primary side
   input  wire logic          pcpl_valid,
   output logic               pcpl_ready,
   input  wire logic [TW-1:0] pcpl_tag,
   input  wire logic [DW-1:0] pcpl_data,
   // completions to the secondary side
   output logic               scpl_valid,
   input  wire logic          scpl_ready,
   output logic [TW-1:0]      scpl_tag,
   output logic [DW-1:0]      scpl_data,
   output logic [2:0]         scpl_status,
   // downstream address claim
   input  wire logic          dn_valid,
   input  wire logic          dn_io,
   input  wire logic [AW-1:0] dn_addr,
   input  wire logic [AW-1:0] memory_window_base,
   input  wire logic [AW-1:0] memory_window_limit,
   input  wire logic [AW-1:0] prefetch_window_base,
   input  wire logic [AW-1:0] prefetch_window_limit,
   input  wire logic [AW-1:0] io_window_base,
   input  wire logic [AW-1:0] io_window_limit,
   output logic               dn_claim
);
   import bcs_pkg::*;

   bcs_link_if #(.TW(TW)) lnk ();

   logic [15:0] bridge_command;
   logic [15:0] bridge_status;
   logic [15:0] cmd_mask;
   logic        system_error_signaled;
   logic        master_parity_error_flag;
   logic        parity_response_enable;
   logic        upstream_master_enable;
   logic        memory_window_enable;
   logic        io_window_enable;
   logic        system_error_msg_enable;
   logic        wr_cmd;
   logic        wr_sts;
   logic        rd_cmd;
   logic        rd_sts;
   logic        serr_fire;
   logic        serr_clr;
   logic        mem_hit;
   logic        io_hit;

   function automatic logic [15:0] be_mask(input logic [1:0] be);
      return {{8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic in_win(input logic [AW-1:0] a,
                                   input logic [AW-1:0] lo,
                                   input logic [AW-1:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // command fields
   assign parity_response_enable  = bridge_command[CMD_PARITY_BIT];
   assign upstream_master_enable  = bridge_command[CMD_MASTER_BIT];
   assign memory_window_enable    = bridge_command[CMD_MEMWIN_BIT];
   assign io_window_enable        = bridge_command[CMD_IOWIN_BIT];
   assign system_error_msg_enable = bridge_command[CMD_SERRMSG_BIT];
   assign lnk.master_en           = upstream_master_enable;

   // configuration decode
   assign wr_cmd   = cfg_req & cfg_we & (cfg_addr == CMD_OFF);
   assign wr_sts   = cfg_req & cfg_we & (cfg_addr == STS_OFF);
   assign rd_cmd   = cfg_req & ~cfg_we & (cfg_addr == CMD_OFF);
   assign rd_sts   = cfg_req & ~cfg_we & (cfg_addr == STS_OFF);
   assign cmd_mask = be_mask(cfg_be) & CMD_WMASK;

   // command register
   always_ff @(posedge clk) begin
      if (rst) begin
         bridge_command <= CMD_RESET;
      end else if (wr_cmd) begin
         bridge_command <= (bridge_command & ~cmd_mask) | (cfg_wdata & cmd_mask);
      end
   end

   // system error message generation
   assign serr_fire = (err_fatal | err_nonfatal) & system_error_msg_enable;
   assign serr_clr  = wr_sts & cfg_be[1] & cfg_wdata[STS_SYSERR_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         serr_msg <= 1'b0;
      end else begin
         serr_msg <= serr_fire;
      end
   end

   // system error signalled; a new event beats a clear
   always_ff @(posedge clk) begin
      if (rst) begin
         system_error_signaled <= 1'b0;
      end else if (serr_fire) begin
         system_error_signaled <= 1'b1;
      end else if (serr_clr) begin
         system_error_signaled <= 1'b0;
      end
   end

   // master parity error flag, settable only while response is enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         master_parity_error_flag <= 1'b0;
      end else if (mdpe_event & parity_response_enable) begin
         master_parity_error_flag <= 1'b1;
      end else if (wr_sts & cfg_be[1] & cfg_wdata[STS_MPE_BIT]) begin
         master_parity_error_flag <= 1'b0;
      end
   end

   // status word view
   always_comb begin
      bridge_status               = STS_RESET;
      bridge_status[STS_SYSERR_BIT] = system_error_signaled;
      bridge_status[STS_MPE_BIT]    = master_parity_error_flag;
      bridge_status[STS_PARDET_BIT] = 1'b0;
      bridge_status[STS_MABORT_BIT] = 1'b0;
   end

   // configuration read answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_ack   <= 1'b0;
         cfg_rdata <= 16'h0000;
      end else begin
         cfg_ack <= cfg_req;
         if (rd_cmd) begin
            cfg_rdata <= bridge_command;
         end else if (rd_sts) begin
            cfg_rdata <= bridge_status;
         end else begin
            cfg_rdata <= 16'h0000;
         end
      end
   end

   // downstream window claim
   assign mem_hit = memory_window_enable &
                    (in_win(dn_addr, memory_window_base, memory_window_limit) |
                     in_win(dn_addr, prefetch_window_base, prefetch_window_limit));
   assign io_hit  = io_window_enable &
                    in_win(dn_addr, io_window_base, io_window_limit);

   always_ff @(posedge clk) begin
      if (rst) begin
         dn_claim <= 1'b0;
      end else begin
         dn_claim <= dn_valid & (dn_io ? io_hit : mem_hit);
      end
   end

   bcs_fwd #(.AW(AW), .DW(DW), .TW(TW)) u_fwd (
      .clk       (clk),
      .rst       (rst),
      .lnk       (lnk),
      .up_valid  (up_valid),
      .up_ready  (up_ready),
      .up_write  (up_write),
      .up_io     (up_io),
      .up_addr   (up_addr),
      .up_be     (up_be),
      .up_data   (up_data),
      .up_tag    (up_tag),
      .pri_valid (pri_valid),
      .pri_ready (pri_ready),
      .pri_write (pri_write),
      .pri_io    (pri_io),
      .pri_addr  (pri_addr),
      .pri_be    (pri_be),
      .pri_data  (pri_data),
      .pri_tag   (pri_tag),
      .ill_valid (ill_valid),
      .ill_ready (ill_ready)
   );

   bcs_cpl #(.DW(DW), .TW(TW)) u_cpl (
      .clk         (clk),
      .rst         (rst),
      .lnk         (lnk),
      .pcpl_valid  (pcpl_valid),
      .pcpl_ready  (pcpl_ready),
      .pcpl_tag    (pcpl_tag),
      .pcpl_data   (pcpl_data),
      .scpl_valid  (scpl_valid),
      .scpl_ready  (scpl_ready),
      .scpl_tag    (scpl_tag),
      .scpl_data   (scpl_data),
      .scpl_status (scpl_status)
   );

   property p_mpe_gate;
      @(posedge clk) disable iff (rst)
         !parity_response_enable && !master_parity_error_flag |=> !master_parity_error_flag;
   endproperty
   a_mpe_gate: assert property (p_mpe_gate)
      else $error("parity flag set while response disabled");

   property p_mem_claim;
      @(posedge clk) disable iff (rst) dn_valid && !dn_io && !memory_window_enable |=> !dn_claim;
   endproperty
   a_mem_claim: assert property (p_mem_claim)
      else $error("memory claimed while memory window disabled");

   property p_io_claim;
      @(posedge clk) disable iff (rst) dn_valid && dn_io && !io_window_enable |=> !dn_claim;
   endproperty
   a_io_claim: assert property (p_io_claim)
      else $error("I/O claimed while I/O window disabled");

   property p_syserr_set;
      @(posedge clk) disable iff (rst)
         (err_fatal || err_nonfatal) && system_error_msg_enable |=> serr_msg && system_error_signaled;
   endproperty
   a_syserr_set: assert property (p_syserr_set)
      else $error("system error sent but status not set");

   property p_syserr_hold;
      @(posedge clk) disable iff (rst)
         !system_error_signaled && !serr_fire |=> !system_error_signaled;
   endproperty
   a_syserr_hold: assert property (p_syserr_hold)
      else $error("system error status set without a sent message");

   property p_pardet_zero;
      @(posedge clk) disable iff (rst) $past(rd_sts) |-> cfg_ack && !cfg_rdata[STS_PARDET_BIT];
   endproperty
   a_pardet_zero: assert property (p_pardet_zero)
      else $error("detected parity error read as one");

   property p_mabort_zero;
      @(posedge clk) disable iff (rst) $past(rd_sts) |-> !cfg_rdata[STS_MABORT_BIT];
   endproperty
   a_mabort_zero: assert property (p_mabort_zero)
      else $error("received master abort read as one");

   property p_syserr_clear;
      @(posedge clk) disable iff (rst) serr_clr && !serr_fire |=> !system_error_signaled;
   endproperty
   a_syserr_clear: assert property (p_syserr_clear)
      else $error("write one did not clear system error status");
endmodule
`default_nettype wire

//--- tb_bridge_command_status_bits.sv
// self-checking bench for the bridge command and status bits
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_command_status_bits;
   import bcs_pkg::*;
   logic        clk, rst, cfg_req, cfg_we, cfg_ack, err_fatal, err_nonfatal, mdpe_event;
   logic        serr_msg, up_valid, up_ready, up_write, up_io, pri_valid, pri_ready;
   logic        pri_write, pri_io, ill_valid, ill_ready, pcpl_valid, pcpl_ready;
   logic        scpl_valid, scpl_ready, dn_valid, dn_io, dn_claim;
   logic [7:0]  cfg_addr, up_tag, pri_tag, pcpl_tag, scpl_tag;
   logic [1:0]  cfg_be;
   logic [2:0]  scpl_status;
   logic [3:0]  up_be, pri_be;
   logic [15:0] cfg_wdata, cfg_rdata, rd_q;
   logic [31:0] up_addr, up_data, pri_addr, pri_data, pcpl_data, scpl_data, dn_addr;
   logic [31:0] memory_window_base, memory_window_limit, prefetch_window_base;
   logic [31:0] prefetch_window_limit, io_window_base, io_window_limit;
   int          fail_count = 0;
   int          checks = 0;
   logic        master_on = 1'b0;
   bcs_top dut (
      .clk, .rst, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata,
      .err_fatal, .err_nonfatal, .mdpe_event, .serr_msg, .up_valid, .up_ready, .up_write,
      .up_io, .up_addr, .up_be, .up_data, .up_tag, .pri_valid, .pri_ready, .pri_write,
      .pri_io, .pri_addr, .pri_be, .pri_data, .pri_tag, .ill_valid, .ill_ready, .pcpl_valid,
      .pcpl_ready, .pcpl_tag, .pcpl_data, .scpl_valid, .scpl_ready, .scpl_tag, .scpl_data,
      .scpl_status, .dn_valid, .dn_io, .dn_addr, .memory_window_base, .memory_window_limit,
      .prefetch_window_base, .prefetch_window_limit, .io_window_base, .io_window_limit,
      .dn_claim);
   bcs_pri_model pm (.clk, .rst, .pri_valid, .ill_valid, .pri_ready, .ill_ready,
      .pcpl_ready, .pcpl_valid, .pcpl_tag, .pcpl_data);
   always #50 clk = ~clk;
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic give_up(input int n);
      if (n >= 40) begin
         fail_count++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         close_out;
      end
   endtask
   task automatic cfg(input logic we, input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = {1'b1, we, a, 2'h3, d};
      @(negedge clk);
      {cfg_req, cfg_wdata} = {1'b0, ~d};
      chk(cfg_ack, 1'b1, "ack");
      rd_q = cfg_rdata;
      if (we && a == CMD_OFF) master_on = d[CMD_MASTER_BIT];
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      cfg(1'b0, a, 16'h0000);
      chk(rd_q, exp, "read");
   endtask
   task automatic evt(input logic [2:0] sel, input logic serr_exp);
      @(negedge clk);
      {err_fatal, err_nonfatal, mdpe_event} = sel;
      @(negedge clk);
      {err_fatal, err_nonfatal, mdpe_event} = 3'h0;
      chk(serr_msg, serr_exp, "serr");
   endtask
   task automatic up(input logic w, input logic io, input logic [31:0] a,
                     input logic [3:0] be, input logic [7:0] t);
      int n;
      @(negedge clk);
      {up_valid, up_write, up_io, up_addr, up_be, up_data, up_tag} = {1'b1, w, io, a, be, ~a, t};
      n = 0;
      while (up_ready !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      give_up(n);
      @(negedge clk);
      {up_valid, up_addr, up_data} = {1'b0, ~a, a};
   endtask
   task automatic take(input logic ill, input logic [31:0] a, input logic [3:0] be,
                       input logic [7:0] t);
      int n;
      n = 0;
      while (!((pri_valid && pri_ready) || (ill_valid && ill_ready)) && n < 40) begin
         @(negedge clk);
         n++;
      end
      give_up(n);
      chk({ill_valid, pri_valid, pri_addr, pri_be, pri_tag}, {ill, ~ill, a, be, t}, "request");
      if (!ill) chk({pri_write, pri_io, pri_data}, {up_write, up_io, ~a}, "payload");
      @(negedge clk);
   endtask
   task automatic cpl(input logic [7:0] t, input logic [31:0] d, input logic [2:0] st);
      int n;
      n = 0;
      while (scpl_valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      give_up(n);
      chk({scpl_tag, scpl_status}, {t, st}, "completion");
      if (st === CPL_SC) chk(scpl_data, d, "completion data");
      @(negedge clk);
   endtask
   task automatic probe(input logic io, input logic [31:0] a, input logic exp);
      @(negedge clk);
      {dn_valid, dn_io, dn_addr} = {1'b1, io, a};
      @(negedge clk);
      {dn_valid, dn_addr} = {1'b0, ~a};
      chk(dn_claim, exp, "claim");
   endtask
   // no primary request while master enable is off
   always @(negedge clk) begin
      if (!rst && !master_on) chk(pri_valid, 1'b0, "primary request");
   end
   initial begin
      {clk, cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata, err_fatal, err_nonfatal} = '0;
      {mdpe_event, up_valid, up_write, up_io, up_addr, up_be, up_data, up_tag} = '0;
      {dn_valid, dn_io, dn_addr} = '0;
      {rst, scpl_ready} = 2'h3;
      {memory_window_base, memory_window_limit} = {32'h0000_1000, 32'h0000_1FFF};
      {prefetch_window_base, prefetch_window_limit} = {32'h0000_8000, 32'h0000_8FFF};
      {io_window_base, io_window_limit} = {32'h0000_0100, 32'h0000_01FF};
      repeat (20) @(negedge clk);
      rst = 1'b0;
      rd(CMD_OFF, CMD_RESET);
      rd(STS_OFF, STS_RESET);
      rd(8'h08, 16'h0000);
      wr_loop: begin
         cfg(1'b1, CMD_OFF, 16'hFFFB);
         rd(CMD_OFF, CMD_WMASK & 16'hFFFB);
         cfg(1'b1, STS_OFF, 16'hFFFF);
         rd(STS_OFF, STS_RESET);
      end
      cfg(1'b1, CMD_OFF, 16'h0000);
      evt(3'h1, 1'b0);
      rd(STS_OFF, STS_RESET);
      cfg(1'b1, CMD_OFF, 16'h0040);
      evt(3'h1, 1'b0);
      rd(STS_OFF, 16'h0110);
      cfg(1'b1, STS_OFF, 16'h0100);
      rd(STS_OFF, STS_RESET);
      evt(3'h4, 1'b0);
      rd(STS_OFF, STS_RESET);
      cfg(1'b1, CMD_OFF, 16'h0100);
      evt(3'h4, 1'b1);
      rd(STS_OFF, 16'h4010);
      cfg(1'b1, STS_OFF, 16'h0000);
      rd(STS_OFF, 16'h4010);
      cfg(1'b1, STS_OFF, 16'h4000);
      rd(STS_OFF, STS_RESET);
      evt(3'h2, 1'b1);
      cfg(1'b1, CMD_OFF, 16'h0000);
      up(1'b1, 1'b0, 32'h0000_2000, 4'hF, 8'h11);
      take(1'b1, ILL_ADDR, 4'h0, 8'h11);
      pm.stall = 2;
      up(1'b0, 1'b0, 32'h0000_2004, 4'hF, 8'h12);
      take(1'b1, ILL_ADDR, 4'hF, 8'h12);
      cpl(8'h12, 32'h0, CPL_UR);
      pm.send_cpl(8'h21, 32'hA5A5_0001);
      cpl(8'h21, 32'hA5A5_0001, CPL_SC);
      cfg(1'b1, CMD_OFF, 16'h0004);
      up(1'b1, 1'b1, 32'h0000_0180, 4'h3, 8'h13);
      take(1'b0, 32'h0000_0180, 4'h3, 8'h13);
      up(1'b0, 1'b0, 32'h0000_3000, 4'hF, 8'h14);
      take(1'b0, 32'h0000_3000, 4'hF, 8'h14);
      pm.send_cpl(8'h14, 32'h1234_5678);
      cpl(8'h14, 32'h1234_5678, CPL_SC);
      for (int c = 0; c < 4; c++) begin
         cfg(1'b1, CMD_OFF, 16'(c));
         probe(1'b0, 32'h0000_1800, c[1]);
         probe(1'b0, 32'h0000_8004, c[1]);
         probe(1'b0, 32'h0000_3000, 1'b0);
         probe(1'b1, 32'h0000_0150, c[0]);
      end
      close_out;
   end
endmodule
`default_nettype wire
